// ===== design/tcu_top.sv
// How it works
// R1: run register 0 halts, 1 starts
// R2: function 0 timer, 1 count, 4 PWM, 3 decrements
// R3: reload register holds 1 to all ones; the code still loads zero into it on a count write of zero
// R4: count write loads reload and count
// R5: count read returns live count undisturbed
// R6: input mask bit n enables line n
// R7: counter mask bit 0 enables zero event
// R8: masks read back last written value
// R9: zero and input events set status bits
// R10: status read returns bits then clears
// R11: global enable gates request, masks kept
// R12: status latches even with global disable
// R13: gate mode freezes count on line zero
// R14: output mode drives line zero on zero
// R15: repeat 0 stops at zero, 1 reloads
// R16: pulse width counted in microsecond ticks
// R17: request while enabled unmasked status set
// R18: timer per tick, counter per input edge
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module tcu_top
  import tcu_pkg::*;
(
  input  wire logic              MCLK,
  input  wire logic              RESET,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  input  wire logic [7:0]        INPUT_LINES,
  output logic                   OUTPUT_LINE_ZERO,
  output logic                   PLAIN_OUT_VALUE,
  output logic                   IRQ
);
  tcu_cfg_t    cfg_reg;
  logic [31:0] reload_reg;
  logic [31:0] count_reg;
  logic [15:0] width_reg;
  logic [7:0]  in_mask_reg;
  logic [7:0]  ct_mask_reg;
  logic [7:0]  in_flags_reg;
  logic [7:0]  ct_flags_reg;
  logic        global_en_reg;
  logic        plain_reg;
  logic [7:0]  lines;
  logic [7:0]  lines_prev_reg;
  logic        tick;
  tcu_sync u_sync (.clk(MCLK), .rst(RESET), .d(INPUT_LINES), .q(lines));
  tcu_tick u_tick (.clk(MCLK), .rst(RESET), .tick(tick));
  // write channel: address and data latched independently, either order
  logic [ADDR_W-1:0] aw_reg;
  logic              aw_full_reg;
  logic [31:0]       w_reg;
  logic [3:0]        ws_reg;
  logic              w_full_reg;
  logic              wr_go;
  logic [4:0]        wr_idx;
  logic              wr_ok;
  assign wr_go  = aw_full_reg && w_full_reg && !S_AXI_BVALID;
  assign wr_idx = aw_reg[ADDR_W-1:2];
  assign wr_ok  = (wr_idx <= IDX_GLOBAL) && (wr_idx != IDX_IN_FLAGS) && (wr_idx != IDX_CT_FLAGS);
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      aw_full_reg   <= 1'b0;
      aw_reg        <= '0;
      S_AXI_AWREADY <= 1'b0;
    end
    else
    begin
      S_AXI_AWREADY <= !aw_full_reg && !(S_AXI_AWVALID && S_AXI_AWREADY);
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_reg      <= S_AXI_AWADDR;
        aw_full_reg <= 1'b1;
      end
      else if (wr_go)
        aw_full_reg <= 1'b0;
    end
  end
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      w_full_reg   <= 1'b0;
      w_reg        <= 32'h0000_0000;
      ws_reg       <= 4'h0;
      S_AXI_WREADY <= 1'b0;
    end
    else
    begin
      S_AXI_WREADY <= !w_full_reg && !(S_AXI_WVALID && S_AXI_WREADY);
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_reg      <= S_AXI_WDATA;
        ws_reg     <= S_AXI_WSTRB;
        w_full_reg <= 1'b1;
      end
      else if (wr_go)
        w_full_reg <= 1'b0;
    end
  end
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
      S_AXI_BVALID <= 1'b0;
  end
  // byte-lane merge of the pending write data onto the old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction
  logic [31:0] wv_cfg, wv_reload, wv_count;
  assign wv_reload = merge(reload_reg, w_reg, ws_reg);
  assign wv_count  = merge(count_reg, w_reg, ws_reg);
  assign wv_cfg    = merge(32'h0000_0000, w_reg, ws_reg);
  logic wr_func, wr_count, wr_reload;
  assign wr_func   = wr_go && wr_idx == IDX_FUNC;
  assign wr_count  = wr_go && wr_idx == IDX_COUNT;
  assign wr_reload = wr_go && wr_idx == IDX_RELOAD;
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      cfg_reg       <= '0;
      width_reg     <= RST_WIDTH;
      in_mask_reg   <= 8'h00;
      ct_mask_reg   <= 8'h00;
      global_en_reg <= 1'b0;
      plain_reg     <= 1'b0;
    end
    else if (wr_go)
    begin
      case (wr_idx)
        IDX_RUN:     cfg_reg.run <= wv_cfg[0]; // R1
        IDX_FUNC:
          if (wv_cfg[2:0] != FN_MANDEC) // R2
            cfg_reg.func <= wv_cfg[2:0];
        IDX_GATE:    cfg_reg.gate <= wv_cfg[1:0];
        IDX_OUT:     cfg_reg.outm <= wv_cfg[2:0];
        IDX_REPEAT:  cfg_reg.repeat_on <= wv_cfg[0];
        IDX_WIDTH:   width_reg <= wv_cfg[15:0];
        IDX_IN_MASK: in_mask_reg <= wv_cfg[7:0]; // R6 R8
        IDX_CT_MASK: ct_mask_reg <= wv_cfg[7:0]; // R7 R8
        IDX_GLOBAL:
        begin
          global_en_reg <= wv_cfg[0]; // R11
          plain_reg     <= wv_cfg[1];
        end
        default: ;
      endcase
    end
  end
  logic gate_open, in0_rise, step, at_zero, manual_dec;
  assign in0_rise = lines[0] && !lines_prev_reg[0];
  always_comb
  begin
    case (cfg_reg.gate) // R13
      GT_HIGH: gate_open = lines[0];
      GT_LOW:  gate_open = !lines[0];
      default: gate_open = 1'b1;
    endcase
  end
  assign step = cfg_reg.run && gate_open && (count_reg != 32'h0000_0000) &&
                ((cfg_reg.func == FN_COUNTER) ? in0_rise : tick); // R18
  assign manual_dec = wr_func && wv_cfg[2:0] == FN_MANDEC && count_reg != 32'h0000_0000; // R2
  assign at_zero    = (step || manual_dec) && count_reg == 32'h0000_0001;
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      count_reg  <= RST_RELOAD;
      reload_reg <= RST_RELOAD;
    end
    else if (wr_count)
    begin
      count_reg  <= wv_count; // R4
      reload_reg <= wv_count; // R4
    end
    else
    begin
      if (wr_reload && wv_reload != 32'h0000_0000)
        reload_reg <= wv_reload; // R3
      if (at_zero && cfg_reg.repeat_on)
        count_reg <= reload_reg; // R15
      else if (step || manual_dec)
        count_reg <= count_reg - 32'h0000_0001; // R15
    end
  end
  logic [15:0] pulse_cnt_reg;
  logic        level_reg;
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      pulse_cnt_reg    <= 16'h0000;
      level_reg        <= 1'b0;
      OUTPUT_LINE_ZERO <= 1'b0;
      PLAIN_OUT_VALUE  <= 1'b0;
    end
    else
    begin
      if (wr_go && wr_idx == IDX_OUT)
        level_reg <= 1'b0;
      else if (at_zero && cfg_reg.outm == OM_LEVEL)
        level_reg <= 1'b1; // R14
      else if (at_zero && cfg_reg.outm == OM_TOGGLE)
        level_reg <= !level_reg; // R14
      if (at_zero && cfg_reg.outm == OM_PULSE)
        pulse_cnt_reg <= width_reg; // R16
      else if (tick && pulse_cnt_reg != 16'h0000)
        pulse_cnt_reg <= pulse_cnt_reg - 16'h0001; // R16
      PLAIN_OUT_VALUE <= plain_reg;
      case (cfg_reg.outm) // R14
        OM_PULSE:  OUTPUT_LINE_ZERO <= pulse_cnt_reg != 16'h0000;
        OM_LEVEL:  OUTPUT_LINE_ZERO <= level_reg;
        OM_TOGGLE: OUTPUT_LINE_ZERO <= level_reg;
        default:   OUTPUT_LINE_ZERO <= plain_reg;
      endcase
    end
  end
  // read channel
  logic [4:0] rd_idx;
  logic       rd_take, rd_in_flags, rd_ct_flags;
  assign rd_idx  = S_AXI_ARADDR[ADDR_W-1:2];
  assign rd_take = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_in_flags = rd_take && rd_idx == IDX_IN_FLAGS;
  assign rd_ct_flags = rd_take && rd_idx == IDX_CT_FLAGS;
  always_ff @(posedge MCLK)
  begin
    if (RESET)
      S_AXI_ARREADY <= 1'b0;
    else
      S_AXI_ARREADY <= !S_AXI_RVALID && !rd_take;
  end
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= RESP_OKAY;
      case (rd_idx)
        IDX_RUN:      S_AXI_RDATA <= {31'h0, cfg_reg.run};
        IDX_FUNC:     S_AXI_RDATA <= {29'h0, cfg_reg.func};
        IDX_GATE:     S_AXI_RDATA <= {30'h0, cfg_reg.gate};
        IDX_OUT:      S_AXI_RDATA <= {29'h0, cfg_reg.outm};
        IDX_REPEAT:   S_AXI_RDATA <= {31'h0, cfg_reg.repeat_on};
        IDX_RELOAD:   S_AXI_RDATA <= reload_reg;
        IDX_COUNT:    S_AXI_RDATA <= count_reg; // R5
        IDX_WIDTH:    S_AXI_RDATA <= {16'h0, width_reg};
        IDX_IN_MASK:  S_AXI_RDATA <= {24'h0, in_mask_reg}; // R8
        IDX_CT_MASK:  S_AXI_RDATA <= {24'h0, ct_mask_reg}; // R8
        IDX_IN_FLAGS: S_AXI_RDATA <= {24'h0, in_flags_reg}; // R10
        IDX_CT_FLAGS: S_AXI_RDATA <= {24'h0, ct_flags_reg}; // R10
        IDX_GLOBAL:   S_AXI_RDATA <= {30'h0, plain_reg, global_en_reg};
        default:
        begin
          S_AXI_RDATA <= 32'h0000_0000;
          S_AXI_RRESP <= RESP_SLVERR;
        end
      endcase
    end
    else if (S_AXI_RREADY)
      S_AXI_RVALID <= 1'b0;
  end
  // event flags: a new event in the clearing cycle survives the clear
  logic [7:0] in_event;
  assign in_event = lines ^ lines_prev_reg;
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      lines_prev_reg <= 8'h00;
      in_flags_reg   <= 8'h00;
      ct_flags_reg   <= 8'h00;
      IRQ            <= 1'b0;
    end
    else
    begin
      lines_prev_reg <= lines;
      in_flags_reg   <= (rd_in_flags ? 8'h00 : in_flags_reg) | in_event; // R9 R10 R12
      ct_flags_reg   <= (rd_ct_flags ? 8'h00 : ct_flags_reg) | {7'h0, at_zero}; // R9 R10 R12
      IRQ            <= global_en_reg && (|(in_flags_reg & in_mask_reg) || |(ct_flags_reg & ct_mask_reg)); // R17 R11 R6 R7
    end
  end
  AST_IRQ_GATED: assert property (@(posedge MCLK) disable iff (RESET)
    !global_en_reg |=> !IRQ) else $error("irq raised while globally disabled"); // R11
  AST_IRQ_FOLLOWS: assert property (@(posedge MCLK) disable iff (RESET)
    (global_en_reg && (ct_flags_reg[0] && ct_mask_reg[0])) |=> IRQ) else $error("irq missing"); // R17
  AST_ZERO_FLAG: assert property (@(posedge MCLK) disable iff (RESET)
    at_zero |=> ct_flags_reg[0]) else $error("zero event not latched"); // R9
  AST_IN_FLAG: assert property (@(posedge MCLK) disable iff (RESET)
    |in_event |=> (in_flags_reg & $past(in_event)) == $past(in_event)) else $error("input event not latched"); // R12
  AST_RD_CLEAR: assert property (@(posedge MCLK) disable iff (RESET)
    (rd_ct_flags && !at_zero) |=> ct_flags_reg == 8'h00) else $error("status not cleared by read"); // R10
  AST_STOP_HOLD: assert property (@(posedge MCLK) disable iff (RESET)
    (!cfg_reg.run && !wr_go) |=> $stable(count_reg)) else $error("count moved while halted"); // R1
  AST_COUNT_LOAD: assert property (@(posedge MCLK) disable iff (RESET)
    wr_count && ws_reg == 4'hf |=> count_reg == $past(w_reg) && reload_reg == $past(w_reg))
    else $error("count write did not load both"); // R4
  AST_SINGLE_STOP: assert property (@(posedge MCLK) disable iff (RESET)
    (at_zero && !cfg_reg.repeat_on && !wr_go) |=> count_reg == 32'h0000_0000 ##1 count_reg == 32'h0000_0000)
    else $error("single cycle did not stop"); // R15
  AST_RELOAD_NZ: assert property (@(posedge MCLK) disable iff (RESET)
    reload_reg != 32'h0000_0000 || $past(wr_count)) else $error("reload became zero"); // R3
endmodule // tcu_top

// ===== design/tcu_pkg.sv
package tcu_pkg;
  // register indices as printed (not multiples of four): byte address = 4 * index
  localparam logic [4:0] IDX_RUN      = 5'h00;
  localparam logic [4:0] IDX_FUNC     = 5'h01;
  localparam logic [4:0] IDX_GATE     = 5'h02;
  localparam logic [4:0] IDX_OUT      = 5'h03;
  localparam logic [4:0] IDX_REPEAT   = 5'h04;
  localparam logic [4:0] IDX_RELOAD   = 5'h05;
  localparam logic [4:0] IDX_COUNT    = 5'h06;
  localparam logic [4:0] IDX_WIDTH    = 5'h07;
  localparam logic [4:0] IDX_IN_MASK  = 5'h08;
  localparam logic [4:0] IDX_CT_MASK  = 5'h09;
  localparam logic [4:0] IDX_IN_FLAGS = 5'h0a;
  localparam logic [4:0] IDX_CT_FLAGS = 5'h0b;
  localparam logic [4:0] IDX_GLOBAL   = 5'h0c;
  localparam int         ADDR_W       = 7;

  localparam logic [2:0] FN_TIMER   = 3'h0;
  localparam logic [2:0] FN_COUNTER = 3'h1;
  localparam logic [2:0] FN_MANDEC  = 3'h3;
  localparam logic [2:0] FN_PWM     = 3'h4;
  localparam logic [1:0] GT_NONE    = 2'h0;
  localparam logic [1:0] GT_HIGH    = 2'h1;
  localparam logic [1:0] GT_LOW     = 2'h2;
  localparam logic [2:0] OM_PLAIN   = 3'h0;
  localparam logic [2:0] OM_PULSE   = 3'h1;
  localparam logic [2:0] OM_LEVEL   = 3'h2;
  localparam logic [2:0] OM_TOGGLE  = 3'h4;

  localparam logic [31:0] RST_RELOAD = 32'h0000_0001;
  localparam logic [15:0] RST_WIDTH  = 16'h0001;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  localparam int CLK_MHZ   = 200;
  localparam int TICK_NS   = 1000;
  localparam int TICK_CYC  = TICK_NS * CLK_MHZ / 1000;

  typedef struct packed {
    logic [2:0] func;
    logic [1:0] gate;
    logic [2:0] outm;
    logic       repeat_on;
    logic       run;
  } tcu_cfg_t;
endpackage

// ===== design/tcu_tick.sv
`timescale 1ns/100ps
module tcu_tick
  import tcu_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  logic [$clog2(TICK_CYC)-1:0] cnt_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end
    else
    begin
      tick <= (cnt_reg == ($clog2(TICK_CYC))'(TICK_CYC - 1));
      if (cnt_reg == ($clog2(TICK_CYC))'(TICK_CYC - 1))
        cnt_reg <= '0;
      else
        cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule // tcu_tick

// ===== design/tcu_sync.sv
`timescale 1ns/100ps
module tcu_sync
  import tcu_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] d,
  output logic      [7:0] q
);
  logic [7:0] meta_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= 8'h00;
      q        <= 8'h00;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule // tcu_sync

// ===== tb/tcu_field_model.sv
`timescale 1ns/100ps
module tcu_field_model
(
  input  wire logic       clk,
  input  wire logic       out_zero,
  output logic      [7:0] lines,
  output int              hi_len
);
  int run_len;

  initial lines = 8'h00;
  initial hi_len = 0;
  initial run_len = 0;

  // length of the last finished high run on the output, so a pulse is judged after it ends
  always @(posedge clk)
  begin
    if (out_zero)
      run_len <= run_len + 1;
    else if (run_len != 0)
    begin
      hi_len  <= run_len;
      run_len <= 0;
    end
  end

  // each level is held four edges, longer than the input synchroniser needs
  task automatic pulse(input int n);
    @(posedge clk);
    lines[n] <= 1'b1;
    repeat (4) @(posedge clk);
    lines[n] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic flip(input int n);
    @(posedge clk);
    lines[n] <= ~lines[n];
    repeat (4) @(posedge clk);
  endtask
endmodule // tcu_field_model

// ===== tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, ex, ac) \
  begin \
    checked++; \
    if ((ac) !== (ex)) \
    begin \
      n_fail++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, ac); \
    end \
  end
module tb_top
  import tcu_pkg::*;
;
  logic              MCLK, RESET, awvalid, wvalid, bready, arvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, got, v;
  logic [3:0]        wstrb;
  logic              awready, wready, bvalid, arready, rvalid, out0, plain, irq, o;
  logic [1:0]        bresp, rresp, resp;
  logic [7:0]        lines;
  int                hi_len, n_fail, checked, cycles;

  tcu_top i_tcu_top (.MCLK(MCLK), .RESET(RESET), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .INPUT_LINES(lines),
    .OUTPUT_LINE_ZERO(out0), .PLAIN_OUT_VALUE(plain), .IRQ(irq));
  tcu_field_model i_tcu_field_model (.clk(MCLK), .out_zero(out0), .lines(lines), .hi_len(hi_len));

  initial
  begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // the whole run is a few thousand cycles; this only cuts a hung handshake short
  always @(posedge MCLK)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK);
  endtask

  task automatic wr(input logic [4:0] i, input logic [31:0] d, input logic [3:0] s = 4'hf);
    @(posedge MCLK);
    awaddr  <= {i, 2'b00};
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    fork
      begin
        do @(posedge MCLK); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge MCLK); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    do @(posedge MCLK); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] i);
    @(posedge MCLK);
    araddr  <= {i, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge MCLK); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge MCLK); while (rvalid !== 1'b1);
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rc(input logic [4:0] i, input logic [31:0] e);
    rd(i);
    `CHK($sformatf("register %0d", i), {RESP_OKAY, e}, {resp, got})
  endtask

  task automatic test_reset();
    for (int k = 0; k < 13; k++)
      rc(5'(k), (k >= 5 && k <= 7) ? 32'h1 : 32'h0);
    rd(5'h0d);
    `CHK("unmapped read", {RESP_SLVERR, 32'h0}, {resp, got})
    wr(IDX_IN_FLAGS, 32'hff);
    `CHK("flags write", RESP_SLVERR, resp)
    wr(IDX_IN_MASK, 32'ha5);
    wr(IDX_CT_MASK, 32'h01);
    rc(IDX_IN_MASK, 32'ha5);
    rc(IDX_CT_MASK, 32'h01);
    $display("test reset and masks done");
  endtask

  task automatic test_counter();
    wr(IDX_COUNT, 32'h3);
    rc(IDX_RELOAD, 32'h3);
    wr(IDX_FUNC, FN_COUNTER);
    wr(IDX_RUN, 32'h1);
    i_tcu_field_model.pulse(0);
    cyc(8);
    rc(IDX_COUNT, 32'h2);
    wr(IDX_FUNC, FN_MANDEC);
    rc(IDX_COUNT, 32'h1);
    rc(IDX_FUNC, FN_COUNTER);
    rc(IDX_CT_FLAGS, 32'h0);
    i_tcu_field_model.pulse(0);
    cyc(8);
    `CHK("irq while disabled", 1'b0, irq)
    rc(IDX_CT_FLAGS, 32'h1);
    rc(IDX_CT_FLAGS, 32'h0);
    rc(IDX_IN_FLAGS, 32'h1);
    rc(IDX_IN_FLAGS, 32'h0);
    i_tcu_field_model.pulse(0);
    cyc(8);
    rc(IDX_COUNT, 32'h0);
    $display("test counter done");
  endtask

  task automatic test_irq();
    rd(IDX_IN_FLAGS);
    rd(IDX_CT_FLAGS);
    wr(IDX_GLOBAL, 32'h1);
    i_tcu_field_model.flip(1);
    cyc(8);
    `CHK("irq masked line", 1'b0, irq)
    i_tcu_field_model.flip(2);
    cyc(8);
    `CHK("irq unmasked line", 1'b1, irq)
    rc(IDX_IN_FLAGS, 32'h6);
    cyc(3);
    `CHK("irq after clear", 1'b0, irq)
    wr(IDX_IN_MASK, 32'h0);
    wr(IDX_COUNT, 32'h1);
    i_tcu_field_model.pulse(0);
    cyc(8);
    `CHK("irq on zero", 1'b1, irq)
    wr(IDX_GLOBAL, 32'h0);
    cyc(3);
    `CHK("irq global off", 1'b0, irq)
    rc(IDX_CT_MASK, 32'h1);
    wr(IDX_CT_MASK, 32'h0);
    wr(IDX_GLOBAL, 32'h1);
    cyc(3);
    `CHK("irq zero masked", 1'b0, irq)
    rd(IDX_IN_FLAGS);
    rd(IDX_CT_FLAGS);
    wr(IDX_GLOBAL, 32'h0);
    $display("test interrupt done");
  endtask

  task automatic test_timer();
    wr(IDX_FUNC, FN_TIMER);
    wr(IDX_COUNT, 32'h5);
    cyc(300);
    rd(IDX_COUNT);
    v = got;
    cyc(300);
    rd(IDX_COUNT);
    `CHK("live count falls", 1'b1, (got < v) && (v < 32'h5) && (got != 0))
    cyc(1200);
    rc(IDX_COUNT, 32'h0);
    rd(IDX_CT_FLAGS);
    wr(IDX_REPEAT, 32'h1);
    wr(IDX_COUNT, 32'h2);
    cyc(1050);
    rd(IDX_COUNT);
    `CHK("reload on zero", 1'b1, (got != 0) && (got <= 32'h2))
    rc(IDX_CT_FLAGS, 32'h1);
    wr(IDX_RUN, 32'h0);
    rd(IDX_COUNT);
    v = got;
    cyc(500);
    rc(IDX_COUNT, v);
    wr(IDX_REPEAT, 32'h0);
    wr(IDX_GATE, GT_HIGH);
    wr(IDX_COUNT, 32'h4);
    wr(IDX_RUN, 32'h1);
    cyc(500);
    rc(IDX_COUNT, 32'h4);
    wr(IDX_GATE, GT_LOW);
    cyc(500);
    rd(IDX_COUNT);
    `CHK("inverted gate counts", 1'b1, got < 32'h4)
    wr(IDX_GATE, GT_NONE);
    $display("test timer done");
  endtask

  task automatic test_output();
    wr(IDX_FUNC, FN_COUNTER);
    wr(IDX_OUT, OM_PULSE);
    wr(IDX_WIDTH, 32'h2);
    wr(IDX_COUNT, 32'h1);
    i_tcu_field_model.pulse(0);
    cyc(600);
    `CHK("pulse width", 1'b1, (hi_len > 200) && (hi_len <= 402))
    wr(IDX_OUT, OM_TOGGLE);
    cyc(2);
    o = out0;
    wr(IDX_COUNT, 32'h1);
    i_tcu_field_model.pulse(0);
    cyc(8);
    `CHK("toggle output", ~o, out0)
    wr(IDX_OUT, OM_LEVEL);
    cyc(2);
    `CHK("level cleared", 1'b0, out0)
    wr(IDX_COUNT, 32'h1);
    i_tcu_field_model.pulse(0);
    cyc(8);
    `CHK("level set", 1'b1, out0)
    wr(IDX_OUT, OM_PLAIN);
    wr(IDX_GLOBAL, 32'h2);
    cyc(3);
    `CHK("plain output", 2'b11, {out0, plain})
    wr(IDX_FUNC, FN_PWM);
    rc(IDX_FUNC, FN_PWM);
    wr(IDX_RELOAD, 32'hffff_ffff);
    wr(IDX_RELOAD, 32'h0);
    rc(IDX_RELOAD, 32'hffff_ffff);
    wr(IDX_RELOAD, 32'h0000_0012, 4'h1);
    rc(IDX_RELOAD, 32'hffff_ff12);
    $display("test output done");
  endtask

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    n_fail = 0;
    checked = 0;
    cycles = 0;
    RESET = 1'b1;
    cyc(2);
    RESET <= 1'b0;
    test_reset();
    test_counter();
    test_irq();
    test_timer();
    test_output();
    end_of_test();
  end
endmodule // tb_top
